/* File: src/kppm_defines.svh */
// Constants for the key-protected pin function selector.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
// Behaviour
// R1: Change needs key one, value, key two.
// R2: Key two must be the next write.
// R3: Readable 8-bit function register, reset zero.
// R4: Software writes zeros into bits 7:2.
// R5: Bit 1 picks SPI (0) or I2C (1).
// R6: Serial choice only acts while bit 0 clear.
// R7: Bit 0 picks analog inputs or digital I/O.
// R8: Broken sequences leave the register unchanged.
`ifndef KPPM_DEFINES_SVH
`define KPPM_DEFINES_SVH
`define KPPM_ADDR_W 32
`define KPPM_KEY_FIRST_ADDR 32'hffff_0464
`define KPPM_FUNC_ADDR 32'hffff_0468
`define KPPM_KEY_SECOND_ADDR 32'hffff_046c
`define KPPM_KEY_FIRST_VAL 16'h0007
`define KPPM_KEY_SECOND_VAL 16'h0013
`define KPPM_FUNC_RESET 8'h00
`define KPPM_ANALOG_BIT 0
`define KPPM_SERIAL_BIT 1
`define KPPM_UNMAPPED_READ 32'h0000_0000
`endif

/* File: src/kppm_pkg.sv */
// Types for the key-protected pin function selector.
// Assumes kppm_defines.svh is compiled alongside.
package kppm_pkg;
    typedef enum logic [1:0] {
        KPPM_ROUTE_GPIO,
        KPPM_ROUTE_ANALOG,
        KPPM_ROUTE_SPI,
        KPPM_ROUTE_I2C
    } kppm_route_t;
    typedef enum logic [1:0] {
        KPPM_SEQ_IDLE,
        KPPM_SEQ_KEYED,
        KPPM_SEQ_VALUE
    } kppm_seq_t;
endpackage

/* File: src/kppm_wr_if.sv */
// Carries one decoded register write from the bus slave to the unlock sequencer.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
interface kppm_wr_if;
    logic wr_stb;
    logic hit_key_first;
    logic hit_func;
    logic hit_key_second;
    logic [15:0] wdata;
    logic commit;
    modport bus (output wr_stb, output hit_key_first, output hit_func,
        output hit_key_second, output wdata, input commit);
    modport seq (input wr_stb, input hit_key_first, input hit_func,
        input hit_key_second, input wdata, output commit);
endinterface
`default_nettype wire

/* File: src/kppm_unlock_seq.sv */
// Unlock sequencer: watches every bus write and signals a committed value.
// Assumes one pulse on wr_stb per accepted bus write.
`timescale 1ns/100ps
`default_nettype none
`include "kppm_defines.svh"
module kppm_unlock_seq (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    kppm_wr_if.seq wr
);
    kppm_pkg::kppm_seq_t state_r;
    kppm_pkg::kppm_seq_t state_nxt;
    wire key1_ok = wr.hit_key_first && (wr.wdata == `KPPM_KEY_FIRST_VAL);
    wire key2_ok = wr.hit_key_second && (wr.wdata == `KPPM_KEY_SECOND_VAL);
    // Any other write in between breaks the sequence, save a valid first key, which restarts it [R2] [R8]
    always_comb begin
        state_nxt = state_r;
        if (wr.wr_stb) begin
            unique case (state_r)
                kppm_pkg::KPPM_SEQ_IDLE:
                    state_nxt = key1_ok ? kppm_pkg::KPPM_SEQ_KEYED : kppm_pkg::KPPM_SEQ_IDLE;
                kppm_pkg::KPPM_SEQ_KEYED: begin
                    if (wr.hit_func)
                        state_nxt = kppm_pkg::KPPM_SEQ_VALUE;
                    else if (key1_ok)
                        state_nxt = kppm_pkg::KPPM_SEQ_KEYED;
                    else
                        state_nxt = kppm_pkg::KPPM_SEQ_IDLE;
                end
                kppm_pkg::KPPM_SEQ_VALUE:
                    state_nxt = key1_ok ? kppm_pkg::KPPM_SEQ_KEYED : kppm_pkg::KPPM_SEQ_IDLE;
                default:
                    state_nxt = kppm_pkg::KPPM_SEQ_IDLE;
            endcase
        end
    end
    // Value only commits on the second key [R1]
    assign wr.commit = wr.wr_stb && key2_ok && (state_r == kppm_pkg::KPPM_SEQ_VALUE);
    always_ff @(posedge clk_in) begin
        if (srst_in)
            state_r <= kppm_pkg::KPPM_SEQ_IDLE;
        else if (ce_in)
            state_r <= state_nxt;
    end
endmodule
`default_nettype wire

/* File: src/kppm_top.sv */
// Key-protected function selector for the four lowest port 0 pins.
// Assumes an Avalon-MM master on clk_in; one wait state per access.
`timescale 1ns/100ps
`default_nettype none
`include "kppm_defines.svh"
module kppm_top (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [31:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [7:0] port0_low_pin_function_out,
    output logic analog_input_choice_out,
    output logic serial_protocol_choice_out,
    output logic route_gpio_out,
    output logic route_analog_out,
    output logic route_spi_out,
    output logic route_i2c_out
);
    kppm_wr_if wr();
    logic [7:0] func_r;
    logic [7:0] staged_r;
    logic [31:0] rdata_r;
    logic wait_done_r;
    logic [7:0] func_nxt;
    kppm_pkg::kppm_route_t route;
    kppm_pkg::kppm_route_t route_nxt;
    logic [1:0] wait_cnt_r;

    // Plain address compare, shared by the three register decodes
    function automatic logic kppm_hit(input logic [31:0] addr, input logic [31:0] target);
        kppm_hit = (addr == target);
    endfunction

    // Analog wins over serial; the serial choice only matters with bit 0 clear
    function automatic kppm_pkg::kppm_route_t kppm_route_of(input logic [7:0] func);
        kppm_route_of = kppm_pkg::KPPM_ROUTE_SPI;
        if (func[`KPPM_ANALOG_BIT])
            kppm_route_of = kppm_pkg::KPPM_ROUTE_ANALOG;
        else if (func[`KPPM_SERIAL_BIT])
            kppm_route_of = kppm_pkg::KPPM_ROUTE_I2C;
    endfunction

    // Waitrequest drops for one cycle after each request; access done on that edge
    wire req = avs_read_in || avs_write_in;
    wire accept = ce_in && req && wait_done_r;
    wire hit_key1 = kppm_hit(avs_address_in, `KPPM_KEY_FIRST_ADDR);
    wire hit_func = kppm_hit(avs_address_in, `KPPM_FUNC_ADDR);
    wire hit_key2 = kppm_hit(avs_address_in, `KPPM_KEY_SECOND_ADDR);
    // Keys need both low byte lanes to carry a full 16-bit key
    wire key_lanes = &avs_byteenable_in[1:0];
    assign wr.wr_stb = accept && avs_write_in;
    assign wr.hit_key_first = hit_key1 && key_lanes;
    assign wr.hit_func = hit_func;
    assign wr.hit_key_second = hit_key2 && key_lanes;
    assign wr.wdata = avs_writedata_in[15:0];
    // Only the function register reads back; keys are write only [R3]
    wire [31:0] rd_mux = hit_func ? {24'h00_0000, func_r} : `KPPM_UNMAPPED_READ;
    // Reserved bits are stored as written; zero is software's job [R4]
    wire [7:0] staged_nxt = avs_byteenable_in[0] ? avs_writedata_in[7:0] : staged_r;
    assign func_nxt = wr.commit ? staged_r : func_r;
    // Analog wins; serial choice only matters when bit 0 is clear [R6] [R7] [R5]
    assign route = kppm_route_of(func_r);
    assign route_nxt = kppm_route_of(func_nxt);
    wire digital_nxt = (route_nxt != kppm_pkg::KPPM_ROUTE_ANALOG); // [R7]
    wire spi_nxt = (route_nxt == kppm_pkg::KPPM_ROUTE_SPI); // [R5] [R6]
    wire i2c_nxt = (route_nxt == kppm_pkg::KPPM_ROUTE_I2C); // [R5] [R6]

    kppm_unlock_seq u_seq (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .wr(wr.seq)
    );
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wait_done_r <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            wait_done_r <= req && !wait_done_r;
            avs_waitrequest_out <= !(req && !wait_done_r);
            rdata_r <= rd_mux;
        end
    end
    assign avs_readdata_out = rdata_r;

    // Cycles a request has waited; the slave should never stall past one
    wire [1:0] wait_cnt_nxt = (req && avs_waitrequest_out) ? wait_cnt_r + 2'h1 : 2'h0;
    always_ff @(posedge clk_in) begin
        if (srst_in)
            wait_cnt_r <= 2'h0;
        else if (ce_in)
            wait_cnt_r <= wait_cnt_nxt;
    end

    // Staged value is held back until the second key arrives [R8]
    always_ff @(posedge clk_in) begin
        if (srst_in)
            staged_r <= `KPPM_FUNC_RESET;
        else if (ce_in && wr.wr_stb && hit_func)
            staged_r <= staged_nxt;
    end
    always_ff @(posedge clk_in) begin
        if (srst_in)
            func_r <= `KPPM_FUNC_RESET; // [R3]
        else if (ce_in)
            func_r <= func_nxt; // [R1]
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            port0_low_pin_function_out <= `KPPM_FUNC_RESET;
            analog_input_choice_out <= 1'b0;
            serial_protocol_choice_out <= 1'b0;
            route_gpio_out <= 1'b1;
            route_analog_out <= 1'b0;
            route_spi_out <= 1'b1; // Zero function selects SPI, so no glitch after reset
            route_i2c_out <= 1'b0;
        end else if (ce_in) begin
            port0_low_pin_function_out <= func_nxt;
            analog_input_choice_out <= func_nxt[`KPPM_ANALOG_BIT]; // [R7]
            serial_protocol_choice_out <= func_nxt[`KPPM_SERIAL_BIT]; // [R5]
            route_gpio_out <= digital_nxt;
            route_analog_out <= !digital_nxt;
            route_spi_out <= spi_nxt; // [R6]
            route_i2c_out <= i2c_nxt; // [R6]
        end
    end
    property p_route_matches;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && $past(ce_in) |-> (route_analog_out == (route == kppm_pkg::KPPM_ROUTE_ANALOG))
            && (route_i2c_out == (route == kppm_pkg::KPPM_ROUTE_I2C));
    endproperty
    a_route_matches: assert property (p_route_matches) else $error("route outputs stale"); // [R6]
    property p_no_commit_no_change;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !wr.commit |=> $stable(func_r);
    endproperty
    a_no_commit_no_change: assert property (p_no_commit_no_change) else $error("function changed"); // [R8]
    property p_commit_loads;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && wr.commit |=> func_r == $past(staged_r);
    endproperty
    a_commit_loads: assert property (p_commit_loads) else $error("commit not loaded"); // [R1]
    property p_wait_one;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && req && avs_waitrequest_out && !wait_done_r |=> !avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest stuck"); // [R3]

    sequence s_request_new;
        ce_in && req && avs_waitrequest_out && !wait_done_r;
    endsequence
    sequence s_answer_then_idle;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    // Waitrequest is low for exactly one cycle per access
    property p_wait_release;
        @(posedge clk_in) disable iff (srst_in || !ce_in)
        s_request_new |=> s_answer_then_idle;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("wait low too long"); // [R3]

    property p_wait_bounded;
        @(posedge clk_in) disable iff (srst_in)
        wait_cnt_r <= 2'h1;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded) else $error("request stalled"); // [R3]

    // Reset leaves the pins digital with the serial choice on SPI
    property p_reset_outputs;
        @(posedge clk_in)
        srst_in |=> avs_waitrequest_out && (avs_readdata_out == 32'h0000_0000)
            && (port0_low_pin_function_out == `KPPM_FUNC_RESET) && route_gpio_out
            && route_spi_out && !route_i2c_out && !route_analog_out;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("reset values wrong"); // [R3]

    property p_readback;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && avs_read_in && hit_func |=> avs_readdata_out == {24'h00_0000, $past(func_r)};
    endproperty
    a_readback: assert property (p_readback) else $error("read data wrong"); // [R3]

    // Keys are write only and read back like unmapped space
    property p_unmapped_zero;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && avs_read_in && !hit_func |=> avs_readdata_out == `KPPM_UNMAPPED_READ;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("stray read data"); // [R3]

    sequence s_commit;
        ce_in && wr.commit;
    endsequence
    sequence s_pins_loaded;
        (port0_low_pin_function_out == $past(staged_r))
            && (analog_input_choice_out == $past(staged_r[`KPPM_ANALOG_BIT]))
            && (serial_protocol_choice_out == $past(staged_r[`KPPM_SERIAL_BIT]));
    endsequence
    property p_commit_pins;
        @(posedge clk_in) disable iff (srst_in)
        s_commit |=> s_pins_loaded;
    endproperty
    a_commit_pins: assert property (p_commit_pins) else $error("pins missed commit"); // [R7]

    property p_route_exclusive;
        @(posedge clk_in) disable iff (srst_in)
        !(route_spi_out && route_i2c_out) && (route_gpio_out != route_analog_out);
    endproperty
    a_route_exclusive: assert property (p_route_exclusive) else $error("routes overlap"); // [R6]

    // Only a function write may touch the staged value
    property p_staged_hold;
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !(wr.wr_stb && hit_func) |=> $stable(staged_r);
    endproperty
    a_staged_hold: assert property (p_staged_hold) else $error("staged value moved"); // [R8]

endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the key-protected pin function selector.
// Assumes kppm_top and kppm_defines.svh on the include path; one clock at 250 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "kppm_defines.svh"
module testbench;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] got;
    logic wait_o;
    logic [7:0] func_o;
    logic ana_o, ser_o, r_gpio, r_ana, r_spi, r_i2c;
    int num_errors = 0;
    int checks_done = 0;
    // Each row: function value, then analog, serial, gpio, analog, spi, i2c outputs
    logic [15:0] rows [4] = '{16'h000a, 16'h0124, 16'h0219, 16'h0334};
    always #2 clk_in = ~clk_in;
    kppm_top u_kppm_top (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_o), .port0_low_pin_function_out(func_o),
        .analog_input_choice_out(ana_o), .serial_protocol_choice_out(ser_o),
        .route_gpio_out(r_gpio), .route_analog_out(r_ana), .route_spi_out(r_spi),
        .route_i2c_out(r_i2c));
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        checks_done++;
        if (exp !== act) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, act);
        end
    endtask
    // One whole Avalon access; an edge always passes before the next request rises
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_o !== 1'b0 && n < 50);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            $display("[FAIL] waitrequest expected 0 seen %b", wait_o);
            summarize();
        end
    endtask
    task automatic unl(input logic [31:0] k1, input logic [31:0] v, input logic [31:0] k2);
        bus(1'b1, `KPPM_KEY_FIRST_ADDR, k1);
        bus(1'b1, `KPPM_FUNC_ADDR, v);
        bus(1'b1, `KPPM_KEY_SECOND_ADDR, k2);
    endtask
    task automatic chkfn(input logic [15:0] row);
        repeat (2) @(posedge clk_in);
        chk("function out", {24'h0, row[15:8]}, {24'h0, func_o});
        chk("routes", {26'h0, row[5:0]}, {26'h0, ana_o, ser_o, r_gpio, r_ana, r_spi, r_i2c});
        bus(1'b0, `KPPM_FUNC_ADDR, 32'h0000_0000);
        chk("function read", {24'h0, row[15:8]}, {24'h0, got[7:0]});
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        chkfn(rows[0]);
        $display("reset test done");
        foreach (rows[i]) begin
            unl(32'h0000_0007, {24'h0, rows[i][15:8]}, 32'h0000_0013);
            chkfn(rows[i]);
        end
        $display("table test done");
        unl(32'h0000_0008, 32'h0000_0000, 32'h0000_0013);
        chkfn(rows[3]);
        unl(32'h0000_0007, 32'h0000_0000, 32'h0000_0012);
        chkfn(rows[3]);
        // A stray write between value and second key must break the sequence
        bus(1'b1, `KPPM_KEY_FIRST_ADDR, 32'h0000_0007);
        bus(1'b1, `KPPM_FUNC_ADDR, 32'h0000_0000);
        bus(1'b1, 32'hffff_0400, 32'h0000_0000);
        bus(1'b1, `KPPM_KEY_SECOND_ADDR, 32'h0000_0013);
        chkfn(rows[3]);
        $display("broken sequence test done");
        bus(1'b0, 32'hffff_0400, 32'h0000_0000);
        chk("unmapped read", `KPPM_UNMAPPED_READ, got);
        bus(1'b0, `KPPM_KEY_SECOND_ADDR, 32'h0000_0000);
        chk("key read", 32'h0000_0000, got);
        $display("read test done");
        // Clock enable low must hold a half-done sequence, not drop it
        bus(1'b1, `KPPM_KEY_FIRST_ADDR, 32'h0000_0007);
        ce <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("frozen waitrequest", 32'h0000_0001, {31'h0, wait_o});
        ce <= 1'b1;
        bus(1'b1, `KPPM_FUNC_ADDR, 32'h0000_0001);
        bus(1'b1, `KPPM_KEY_SECOND_ADDR, 32'h0000_0013);
        chkfn(rows[1]);
        $display("clock enable test done");
        // Second reset in mid-run clears the selection and a half-done sequence
        bus(1'b1, `KPPM_KEY_FIRST_ADDR, 32'h0000_0007);
        bus(1'b1, `KPPM_FUNC_ADDR, 32'h0000_0002);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        bus(1'b1, `KPPM_KEY_SECOND_ADDR, 32'h0000_0013);
        chkfn(rows[0]);
        unl(32'h0000_0007, 32'h0000_0002, 32'h0000_0013);
        chkfn(rows[2]);
        $display("second reset test done");
        summarize();
    end
endmodule
`default_nettype wire
